// ==== core/swuds_pkg.sv ====
// Constants, types and the CRC function of the single-wire UART datagram slave.
package swuds_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned MIN_BAUD = 9000;
  localparam int unsigned BIT_W = 12;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned MAX_BIT_CLKS = (CLK_HZ + MIN_BAUD - 1) / MIN_BAUD;
  localparam logic [CNT_W-1:0] SYNC_LIMIT = CNT_W'(4 * MAX_BIT_CLKS);
  localparam logic [CNT_W-1:0] GLITCH_CLKS = 20'h00010;
  localparam logic [CNT_W-1:0] TIMEOUT_BITS = 20'h0003f;
  localparam logic [CNT_W-1:0] RECOV_BITS = 20'h0000c;
  localparam logic [CNT_W-1:0] RELEASE_BITS = 20'h00004;
  localparam logic [6:0] DELAY_UNIT_BITS = 7'h08;
  localparam logic [3:0] LEN_READ = 4'h4;
  localparam logic [3:0] LEN_WRITE = 4'h8;
  localparam logic [7:0] SYNC_BYTE = 8'h05;
  localparam logic [7:0] SYNC_PARTIAL = 8'ha0;
  localparam logic [7:0] REPLY_ADDR = 8'hff;
  localparam int unsigned RW_BIT = 7;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [6:0] CNT_REG_ADDR = 7'h02;

  typedef struct packed {
    logic [6:0] addr;
    logic [31:0] data;
  } swuds_wr_item_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SYNC = 3'b001,
    ST_BITS = 3'b010,
    ST_GAP = 3'b011,
    ST_RECOV = 3'b100,
    ST_DELAY = 3'b101,
    ST_SEND = 3'b110,
    ST_HOLD = 3'b111
  } swuds_state_t;

  function automatic logic [7:0] crc_byte(input logic [7:0] crc_in, input logic [7:0] b);
    logic [7:0] c;
    c = crc_in;
    for (int i = 0; i < 8; i++) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction
endpackage

// ==== core/swuds_fifo.sv ====
// Small synchronous FIFO with a registered output stage.
`timescale 1ns/10ps
module swuds_fifo #(
  parameter int unsigned WIDTH = 39,
  parameter int unsigned DEPTH = 16
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready = count_q < (AW + 1)'(DEPTH);
  assign push = in_valid && in_ready;
  assign pop = (count_q != '0) && (!out_valid || out_ready);

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wptr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= rptr_q + 1'b1;
      end
      count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  // The output stage is a register so the consumer never sees memory timing.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem_q[rptr_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// ==== core/swuds_slave.sv ====
// Single-wire UART datagram slave: auto-baud receiver, reply transmitter, write FIFO.
`timescale 1ns/10ps
module swuds_slave #(
  parameter int unsigned FIFO_DEPTH = 16
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe,
  input wire logic address_select_pin_low,
  input wire logic address_select_pin_high,
  input wire logic [3:0] reply_send_delay,
  input wire logic pdn_disable,
  input wire logic pdn_reg_setting,
  output logic power_down,
  output logic rd_req,
  output logic [6:0] rd_addr,
  input wire logic [31:0] rd_data,
  output logic wr_valid,
  output swuds_pkg::swuds_wr_item_t wr_item,
  input wire logic wr_ready,
  output logic [7:0] dgram_count
);
  import swuds_pkg::*;

  logic line_s1_q;
  logic line_s2_q;
  logic line_prev_q;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  swuds_state_t state_q;
  logic [BIT_W-1:0] bit_q;
  logic [BIT_W-1:0] good_bit_q;
  logic good_q;
  logic [CNT_W-1:0] tmr_q;
  logic [CNT_W-1:0] gap_q;
  logic nfall_q;
  logic [3:0] idx_q;
  logic [3:0] nbyte_q;
  logic [3:0] len_q;
  logic [7:0] sh_q;
  logic [7:0] addr_q;
  logic [7:0] reg_q;
  logic [31:0] data_q;
  logic [7:0] crc_q;
  logic [55:0] tx_buf_q;
  logic [6:0] dly_q;
  logic fall;
  logic [BIT_W-1:0] base_bit;
  logic [CNT_W-1:0] gap_lim;
  logic [CNT_W-1:0] rec_lim;
  logic byte_done;
  logic dg_end;
  logic crc_ok;
  logic ours;
  logic fifo_ready;
  logic push_c;
  logic [7:0] tx_cur;
  swuds_wr_item_t push_item;

  // Pins from outside pass two flops; the edge detector compares the second with its copy one cycle older.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
      line_prev_q <= 1'b1;
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
    end else begin
      line_s1_q <= line_in;
      line_s2_q <= line_s1_q;
      line_prev_q <= line_s2_q;
      pin_s1_q <= {address_select_pin_high, address_select_pin_low};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign fall = line_prev_q && !line_s2_q;
  // The timeout rests on the last good datagram's bit time, so a sudden large
  // baud drop by the master trips it.
  assign base_bit = good_q ? good_bit_q : bit_q;
  assign gap_lim = TIMEOUT_BITS * CNT_W'(base_bit);
  assign rec_lim = RECOV_BITS * CNT_W'(base_bit);
  assign byte_done = (state_q == ST_BITS) && (tmr_q == '0) && (idx_q == 4'h8) && line_s2_q;
  assign dg_end = byte_done && (nbyte_q == len_q - 4'h1);
  assign crc_ok = (sh_q == crc_q);
  assign ours = (addr_q == {6'h00, pin_s2_q});
  assign push_c = dg_end && crc_ok && ours && reg_q[RW_BIT] && fifo_ready;
  assign push_item = '{addr: reg_q[6:0], data: data_q};
  assign tx_cur = (nbyte_q == 4'h7) ? crc_q : tx_buf_q[55:48];

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      bit_q <= '0;
      good_bit_q <= '0;
      good_q <= 1'b0;
      tmr_q <= '0;
      gap_q <= '0;
      nfall_q <= 1'b0;
      idx_q <= 4'h0;
      nbyte_q <= 4'h0;
      len_q <= LEN_WRITE;
      sh_q <= 8'h00;
      addr_q <= 8'h00;
      reg_q <= 8'h00;
      data_q <= 32'h0000_0000;
      crc_q <= 8'h00;
      tx_buf_q <= '0;
      dly_q <= 7'h00;
      line_out <= 1'b1;
      line_oe <= 1'b0;
      rd_req <= 1'b0;
      rd_addr <= 7'h00;
    end else begin
      rd_req <= 1'b0;
      if (state_q inside {ST_SYNC, ST_BITS, ST_GAP}) begin
        gap_q <= gap_q + 1'b1;
      end
      unique case (state_q)
        ST_IDLE: begin
          if (fall) begin
            state_q <= ST_SYNC;
            tmr_q <= 20'h00001;
            gap_q <= '0;
            nfall_q <= 1'b0;
            nbyte_q <= 4'h0;
            len_q <= LEN_WRITE;
            crc_q <= 8'h00;
          end
        end
        ST_SYNC: begin
          tmr_q <= tmr_q + 1'b1;
          if (line_s2_q && tmr_q < GLITCH_CLKS) begin
            state_q <= ST_RECOV;
            tmr_q <= '0;
          end else if (tmr_q > SYNC_LIMIT) begin
            state_q <= ST_RECOV;
            tmr_q <= '0;
          end else if (fall && nfall_q) begin
            // Four bit times have passed; the measurement adapts every datagram.
            bit_q <= tmr_q[BIT_W+1:2];
            tmr_q <= {3'h0, tmr_q[CNT_W-1:3]};
            sh_q <= SYNC_PARTIAL;
            idx_q <= 4'h3;
            state_q <= ST_BITS;
          end else if (fall) begin
            nfall_q <= 1'b1;
          end
        end
        ST_BITS: begin
          if (tmr_q != '0) begin
            tmr_q <= tmr_q - 1'b1;
          end else if (idx_q != 4'h8) begin
            sh_q <= {line_s2_q, sh_q[7:1]};
            idx_q <= idx_q + 4'h1;
            tmr_q <= CNT_W'(bit_q) - 1'b1;
          end else if (!line_s2_q) begin
            state_q <= ST_RECOV;
            tmr_q <= '0;
          end else if (dg_end) begin
            if (!crc_ok) begin
              state_q <= ST_RECOV;
              tmr_q <= '0;
            end else begin
              good_bit_q <= bit_q;
              good_q <= 1'b1;
              state_q <= ST_IDLE;
              if (ours && !reg_q[RW_BIT]) begin
                rd_req <= 1'b1;
                rd_addr <= reg_q[6:0];
                // A zero setting is taken as one unit of eight bit times.
                dly_q <= (reply_send_delay == 4'h0) ? DELAY_UNIT_BITS
                       : {reply_send_delay, 3'h0};
                tmr_q <= CNT_W'(bit_q);
                state_q <= ST_DELAY;
              end
            end
          end else begin
            nbyte_q <= nbyte_q + 4'h1;
            crc_q <= crc_byte(crc_q, sh_q);
            if (nbyte_q == 4'h1) begin
              addr_q <= sh_q;
            end else if (nbyte_q == 4'h2) begin
              reg_q <= sh_q;
              // Replies of other slaves carry 0xff and are eight bytes long.
              len_q <= (sh_q[RW_BIT] || addr_q == REPLY_ADDR) ? LEN_WRITE : LEN_READ;
            end else if (nbyte_q != 4'h0) begin
              data_q <= {data_q[23:0], sh_q};
            end
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (fall) begin
            gap_q <= '0;
            idx_q <= 4'h0;
            tmr_q <= CNT_W'(bit_q) + CNT_W'(bit_q[BIT_W-1:1]) - 1'b1;
            state_q <= ST_BITS;
          end else if (gap_q > gap_lim) begin
            state_q <= ST_IDLE;
          end
        end
        ST_RECOV: begin
          if (!line_s2_q) begin
            tmr_q <= '0;
          end else if (tmr_q >= rec_lim) begin
            state_q <= ST_IDLE;
          end else begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
        ST_DELAY: begin
          if (tmr_q != 20'h00001) begin
            tmr_q <= tmr_q - 1'b1;
          end else if (dly_q != 7'h01) begin
            dly_q <= dly_q - 7'h01;
            tmr_q <= CNT_W'(bit_q);
          end else begin
            tx_buf_q <= {SYNC_BYTE, REPLY_ADDR, reg_q,
                         (reg_q[6:0] == CNT_REG_ADDR) ? {24'h000000, dgram_count}
                         : rd_data};
            crc_q <= 8'h00;
            nbyte_q <= 4'h0;
            idx_q <= 4'h0;
            line_out <= 1'b0;
            line_oe <= 1'b1;
            tmr_q <= CNT_W'(bit_q);
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (tmr_q != 20'h00001) begin
            tmr_q <= tmr_q - 1'b1;
          end else if (idx_q != 4'h9) begin
            tmr_q <= CNT_W'(bit_q);
            idx_q <= idx_q + 4'h1;
            line_out <= (idx_q == 4'h8) ? 1'b1 : tx_cur[idx_q[2:0]];
          end else if (nbyte_q == 4'h7) begin
            tmr_q <= RELEASE_BITS * CNT_W'(bit_q);
            state_q <= ST_HOLD;
          end else begin
            crc_q <= crc_byte(crc_q, tx_cur);
            tx_buf_q <= {tx_buf_q[47:0], 8'h00};
            nbyte_q <= nbyte_q + 4'h1;
            idx_q <= 4'h0;
            line_out <= 1'b0;
            tmr_q <= CNT_W'(bit_q);
          end
        end
        ST_HOLD: begin
          if (tmr_q != 20'h00001) begin
            tmr_q <= tmr_q - 1'b1;
          end else begin
            line_oe <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // A write refused by a full FIFO is not counted in dgram_count, so the master sees it in the count register.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dgram_count <= 8'h00;
    end else if (push_c) begin
      dgram_count <= dgram_count + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      power_down <= 1'b0;
    end else begin
      power_down <= pdn_disable ? pdn_reg_setting : line_s2_q;
    end
  end

  swuds_fifo #(
    .WIDTH($bits(swuds_wr_item_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(push_c),
    .in_ready(fifo_ready),
    .in_data(push_item),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_item)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  property p_line_high;
    (state_q != ST_SEND) |-> line_out;
  endproperty
  a_line_high: assert property (p_line_high) else $error("line not high outside a reply");

  property p_glitch;
    (state_q == ST_SYNC && line_s2_q && tmr_q < GLITCH_CLKS) |=> (state_q == ST_RECOV);
  endproperty
  a_glitch: assert property (p_glitch) else $error("short pulse not treated as glitch");

  property p_recov_exit;
    (state_q == ST_RECOV) ##1 (state_q == ST_IDLE) |-> $past(tmr_q) >= $past(rec_lim);
  endproperty
  a_recov_exit: assert property (p_recov_exit) else $error("recovery left too early");

  property p_timeout;
    (state_q == ST_GAP && !fall && gap_q > gap_lim) |=> (state_q == ST_IDLE);
  endproperty
  a_timeout: assert property (p_timeout) else $error("byte gap timeout missed");

  property p_count_step;
    $changed(dgram_count) |-> $past(push_c) && dgram_count == $past(dgram_count) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter moved without a write");

  property p_push_good;
    push_c |-> line_s2_q && sh_q == crc_q && addr_q < 8'h04 && reg_q[RW_BIT] && nbyte_q == 4'h7;
  endproperty
  a_push_good: assert property (p_push_good) else $error("write taken without a good frame");

  property p_tx_start;
    $rose(line_oe) |-> !line_out ##1 !line_out;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("reply does not open with start bit");

  property p_release;
    $fell(line_oe) |-> $past(state_q) == ST_HOLD && $past(tmr_q) == 20'h00001;
  endproperty
  a_release: assert property (p_release) else $error("driver released at wrong time");

  property p_pdn;
    pdn_disable |=> power_down == $past(pdn_reg_setting);
  endproperty
  a_pdn: assert property (p_pdn) else $error("power-down not taken from register");
endmodule

// ==== sim/swuds_master.sv ====
// Model of the microcontroller UART master that shares the single data line.
`timescale 1ns/10ps
module swuds_master (
  input wire logic mclk,
  input wire logic line,
  output logic m_out,
  output logic m_oe
);
  // Bit time in clocks; kept at 16 or more and never cut to a small fraction at once.
  int bt = 16;

  initial begin
    m_out = 1'b1;
    m_oe = 1'b0;
  end

  function automatic logic [7:0] crc_next(input logic [7:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c[7] ^ b[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // Released between bytes; the line then rests high through its pull-up.
  task automatic send_byte(input logic [7:0] b);
    @(posedge mclk);
    #1;
    for (int i = 0; i < 10; i++) begin
      m_out = (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : b[(i + 7) % 8]);
      m_oe = 1'b1;
      repeat (bt) @(posedge mclk);
      #1;
    end
    m_oe = 1'b0;
  endtask

  task automatic send_dgram(input logic [7:0] node, input logic [7:0] rb, input logic [31:0] d,
    input logic bad);
    logic [7:0] q[$];
    logic [7:0] c;
    q = {8'h05, node, rb};
    // Replies of other slaves carry four data bytes although bit 7 is clear.
    if (rb[7] || node == 8'hff) begin
      q = {q, d[31:24], d[23:16], d[15:8], d[7:0]};
    end
    c = 8'h00;
    foreach (q[i]) c = crc_next(c, q[i]);
    q.push_back(c ^ {7'h00, bad});
    foreach (q[i]) send_byte(q[i]);
  endtask

  task automatic pulse(input int n);
    @(posedge mclk);
    #1;
    m_out = 1'b0;
    m_oe = 1'b1;
    repeat (n) @(posedge mclk);
    #1;
    m_oe = 1'b0;
  endtask

  task automatic recv_byte(output logic [7:0] b, output logic stop);
    int n;
    n = 0;
    while (line !== 1'b0 && n < 4000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    repeat (bt + bt / 2 - 1) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      #1;
      b[i] = line;
      repeat (bt) @(posedge mclk);
    end
    #1;
    stop = line;
  endtask
endmodule

// ==== sim/swuds_slave_test.sv ====
// Self-checking testbench of the single-wire UART datagram slave.
`timescale 1ns/10ps
module swuds_slave_test;
  import swuds_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] node = 2'b10;
  logic [3:0] reply_send_delay = 4'h1;
  logic pdn_disable = 1'b0;
  logic pdn_reg_setting = 1'b0;
  logic [31:0] rd_data = 32'hc35a17e9;
  logic wr_ready = 1'b1;
  logic line_out, line_oe, power_down, rd_req, wr_valid, m_out, m_oe, line;
  logic [6:0] rd_addr;
  logic [7:0] dgram_count;
  logic [7:0] exp_cnt = 8'h00;
  swuds_wr_item_t wr_item;
  logic [38:0] exp_q[$];
  logic [38:0] got_q[$];
  int fails = 0;
  int cmp_count = 0;

  always #25 mclk = ~mclk;
  // Only one party drives at a time; otherwise the pull-up holds the line high.
  assign line = line_oe ? line_out : (m_oe ? m_out : 1'b1);

  swuds_slave #(.FIFO_DEPTH(16)) swuds_slave_i (.mclk(mclk), .resetn(resetn), .line_in(line),
    .line_out(line_out), .line_oe(line_oe), .address_select_pin_low(node[0]),
    .address_select_pin_high(node[1]), .reply_send_delay(reply_send_delay),
    .pdn_disable(pdn_disable), .pdn_reg_setting(pdn_reg_setting), .power_down(power_down),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid),
    .wr_item(wr_item), .wr_ready(wr_ready), .dgram_count(dgram_count));
  swuds_master swuds_master_i (.mclk(mclk), .line(line), .m_out(m_out), .m_oe(m_oe));

  always @(posedge mclk) begin
    if (resetn && wr_valid === 1'b1 && wr_ready === 1'b1) begin
      got_q.push_back(wr_item);
    end
  end

  task automatic stop_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [38:0] e, input logic [38:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      fails++;
    end
  endtask

  // Timing is judged with a small margin for synchroniser and sampling slack.
  task automatic near(input string name, input int e, input int g);
    cmp_count++;
    if (g < e - 3 || g > e + 3) begin
      $display("CHECK FAILED %s expected %0d seen %0d", name, e, g);
      fails++;
    end
  endtask

  task automatic gap(input int bits);
    repeat (bits * swuds_master_i.bt) @(posedge mclk);
    #1;
  endtask

  task automatic items_check();
    check("item count", 39'(exp_q.size()), 39'(got_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0) begin
      check("wr_item", exp_q.pop_front(), got_q.pop_front());
    end
  endtask

  task automatic write_dg(input logic [1:0] na, input logic [6:0] ra, input logic [31:0] d,
    input logic bad, input logic take);
    swuds_master_i.send_dgram({6'h00, na}, {1'b1, ra}, d, bad);
    repeat (6) @(posedge mclk);
    #1;
    if (take) begin
      exp_cnt = exp_cnt + 8'h01;
      exp_q.push_back({ra, d});
    end
    check("dgram_count", 39'(exp_cnt), 39'(dgram_count));
  endtask

  task automatic t_write();
    write_dg(2'b10, 7'h10, 32'h12345678, 1'b0, 1'b1);
    write_dg(2'b01, 7'h10, 32'h0badf00d, 1'b0, 1'b0);
    write_dg(2'b11, 7'h10, 32'h0badf00d, 1'b0, 1'b0);
    swuds_master_i.send_dgram(8'hff, 8'h10, 32'h5a5aa5a5, 1'b0);
    write_dg(2'b10, 7'h14, 32'h00000001, 1'b0, 1'b1);
    items_check();
  endtask

  task automatic t_errors();
    write_dg(2'b10, 7'h11, 32'h0000beef, 1'b1, 1'b0);
    write_dg(2'b10, 7'h11, 32'h0000beef, 1'b0, 1'b0);
    gap(13);
    write_dg(2'b10, 7'h11, 32'h0000beef, 1'b0, 1'b1);
    swuds_master_i.pulse(8);
    gap(4);
    write_dg(2'b10, 7'h12, 32'h00000000, 1'b0, 1'b0);
    gap(13);
    write_dg(2'b10, 7'h12, 32'h00c0ffee, 1'b0, 1'b1);
    swuds_master_i.send_byte(8'h05);
    swuds_master_i.send_byte(8'h02);
    gap(70);
    write_dg(2'b10, 7'h13, 32'h13579bdf, 1'b0, 1'b1);
    items_check();
  endtask

  task automatic t_read(input logic [6:0] ra, input logic [31:0] d, input int t,
    input logic [3:0] dly);
    logic [7:0] ex[8];
    logic [7:0] got;
    logic stp;
    int n;
    int hi;
    ex = '{8'h05, 8'hff, {1'b0, ra}, d[31:24], d[23:16], d[15:8], d[7:0], 8'h00};
    for (int i = 0; i < 7; i++) ex[7] = swuds_master_i.crc_next(ex[7], ex[i]);
    swuds_master_i.bt = t;
    reply_send_delay = dly;
    n = 0;
    fork
      swuds_master_i.send_dgram({6'h00, node}, {1'b0, ra}, 32'h0, 1'b0);
      begin
        while (rd_req !== 1'b1 && n < 20000) begin
          @(posedge mclk);
          #1;
          n++;
        end
        check("rd_req", 39'h1, 39'(rd_req));
        check("rd_addr", 39'(ra), 39'(rd_addr));
        n = 0;
        while (line_oe !== 1'b1 && n < 20000) begin
          @(posedge mclk);
          #1;
          n++;
        end
      end
    join
    near("reply delay", ((dly == 4'h0) ? 8 : 8 * int'(dly)) * t, n);
    check("rd_req after pulse", 39'h0, 39'(rd_req));
    hi = 0;
    fork
      for (int i = 0; i < 8; i++) begin
        swuds_master_i.recv_byte(got, stp);
        check("reply byte", 39'(ex[i]), 39'(got));
        check("reply stop", 39'h1, 39'(stp));
      end
      while (line_oe === 1'b1 && hi < 20000) begin
        @(posedge mclk);
        #1;
        hi++;
      end
    join
    near("driver hold", 84 * t, hi + 1);
    check("idle line", 39'h1, 39'(line));
    check("count after read", 39'(exp_cnt), 39'(dgram_count));
  endtask

  task automatic t_fifo();
    node = 2'b01;
    wr_ready = 1'b0;
    swuds_master_i.bt = 16;
    gap(2);
    for (int i = 0; i < 18; i++) begin
      write_dg(2'b01, 7'(i), {16'(i), 16'h5a00}, 1'b0, i < 17);
    end
    check("wr_valid full", 39'h1, 39'(wr_valid));
    wr_ready = 1'b1;
    gap(3);
    check("wr_valid empty", 39'h0, 39'(wr_valid));
    items_check();
  endtask

  task automatic t_reset();
    gap(12);
    check("count at reset", 39'h0, 39'(dgram_count));
    check("driver at reset", 39'h0, 39'(line_oe));
    check("line_out at reset", 39'h1, 39'(line_out));
    check("wr_valid at reset", 39'h0, 39'(wr_valid));
  endtask

  task automatic t_pdn();
    pdn_disable = 1'b1;
    pdn_reg_setting = 1'b1;
    gap(1);
    check("pdn from register", 39'h1, 39'(power_down));
    pdn_reg_setting = 1'b0;
    gap(1);
    check("pdn pin ignored", 39'h0, 39'(power_down));
    pdn_disable = 1'b0;
    gap(1);
    check("pdn from line", 39'h1, 39'(power_down));
  endtask

  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    stop_test();
  end

  initial begin
    repeat (12) @(posedge mclk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_write();
    t_errors();
    t_read(7'h02, {24'h0, exp_cnt}, 16, 4'h2);
    t_read(7'h21, rd_data, 24, 4'h0);
    t_fifo();
    t_pdn();
    stop_test();
  end
endmodule
